// ===== rtl/tdl_pkg.sv
// Package: constants, register map and carriers for the tach monitor
package tdl_pkg;
  // ==================================================
  // Sizes
  localparam int NUM_CH = 4;
  localparam int NUM_PAIR = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_W = 16;
  localparam int FRAC_W = 8;
  localparam int VOLT_W = 5;
  localparam int HOLD_W = 16;
  // ==================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int HOLD_STEP_MS = 10;
  localparam int HOLD_STEP_CYC = HOLD_STEP_MS * 1000 * CLK_MHZ;
  // ==================================================
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_THR0 = 8'h04;
  localparam logic [7:0] ADR_THR3 = 8'h10;
  localparam logic [7:0] ADR_HOLD = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_MASK = 8'h1C;
  localparam logic [7:0] ADR_TRST = 8'h20;
  localparam logic [7:0] ADR_LIVE = 8'h24;
  // ==================================================
  // Field positions
  localparam int CTRL_DUAL_LSB = 0;
  localparam int CTRL_TRIG_LSB = 4;
  localparam int THR_OFF_LSB = 0;
  localparam int THR_ON_LSB = 8;
  localparam int STAT_OVF_LSB = 2;
  localparam int STAT_W = NUM_PAIR + NUM_CH;
  // ==================================================
  // Reset values
  localparam logic [4:0] OFF_RST = 5'h05;
  localparam logic [4:0] ON_RST = 5'h0B;
  // ==================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [LVL_W-1:0] level;
  } tdl_sample_t;
  typedef struct packed {
    logic [VOLT_W-1:0] off_v;
    logic [VOLT_W-1:0] on_v;
  } tdl_thresh_t;
endpackage : tdl_pkg

// ===== rtl/tdl_pulse_qual.sv
// One channel: hysteresis thresholds and trigger polarity
`timescale 1ns/1ps
module tdl_pulse_qual (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Sample and settings
  input tdl_pkg::tdl_sample_t sample,
  input tdl_pkg::tdl_thresh_t thresh,
  input wire logic invert,
  // Qualified pulse
  output logic pulse
);
  logic sensor_on;
  logic next_sensor_on;
  logic next_pulse;
  logic [tdl_pkg::LVL_W-1:0] on_lvl;
  logic [tdl_pkg::LVL_W-1:0] off_lvl;

  // ==================================================
  // Threshold compare with held state between levels
  always_comb begin
    on_lvl = tdl_pkg::LVL_W'({thresh.on_v, tdl_pkg::FRAC_W'(0)});
    off_lvl = tdl_pkg::LVL_W'({thresh.off_v, tdl_pkg::FRAC_W'(0)});
    next_sensor_on = sensor_on;
    if (sample.valid) begin
      if (sample.level >= on_lvl) begin
        next_sensor_on = 1'b1;
      end else if (sample.level <= off_lvl) begin
        next_sensor_on = 1'b0;
      end
    end
    next_pulse = next_sensor_on ^ invert;
  end

  // State registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sensor_on <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sensor_on <= next_sensor_on;
      pulse <= next_pulse;
    end
  end
endmodule : tdl_pulse_qual

// ===== rtl/tdl_monitor.sv
// Four-channel tach pulse qualifier with paired dual-low diagnostic
// How it works
// - Enabled pair flags fault when both low
// - Diagnostic enable defaults off, no fault then
// - Pairs are 0/1 and 2/3, shared enable
// - Trigger type: falling plain, rising inverted
// - Off threshold 0..23 V, default 5 V
// - On threshold 1..24 V, default 11 V
// - Tach reset clears latched overfrequency
// - Errors held for shared 10 ms steps
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tdl_monitor #(
  parameter int TICK_CYCLES = tdl_pkg::HOLD_STEP_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [tdl_pkg::ADDR_W-1:0] addr,
  input wire logic [tdl_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [tdl_pkg::DATA_W-1:0] rdata,
  // Sensor samples and overfrequency events
  input tdl_pkg::tdl_sample_t [tdl_pkg::NUM_CH-1:0] samples,
  input wire logic [tdl_pkg::NUM_CH-1:0] overfreq_evt,
  // Status outputs
  output logic [tdl_pkg::NUM_CH-1:0] pulse_state,
  output logic [tdl_pkg::NUM_PAIR-1:0] pair_fault,
  output logic [tdl_pkg::NUM_CH-1:0] freq_run,
  output logic irq
);
  // Short local names for sizes
  localparam int NC = tdl_pkg::NUM_CH;
  localparam int NP = tdl_pkg::NUM_PAIR;
  localparam int SW = tdl_pkg::STAT_W;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Configuration and status state
  logic [NP-1:0] dual_en, next_dual_en;
  logic [NC-1:0] trig_inv, next_trig_inv;
  tdl_pkg::tdl_thresh_t [NC-1:0] thr, next_thr;
  logic [tdl_pkg::HOLD_W-1:0] hold_val, next_hold_val;
  logic [SW-1:0] stat, next_stat, mask, next_mask;

  // Overfrequency latches, one per channel
  logic [NC-1:0] ovf_lat, next_ovf_lat;
  // Read data and interrupt next values
  logic [tdl_pkg::DATA_W-1:0] next_rdata;
  logic next_irq;

  // Diagnostic state
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic tick;
  // Hold counters, one per pair
  logic [tdl_pkg::HOLD_W-1:0] hold_cnt [NP];
  logic [tdl_pkg::HOLD_W-1:0] next_hold_cnt [NP];
  // Pair conditions and channel pulses
  logic [NP-1:0] dual_low, next_pair_fault;
  logic [NC-1:0] pulse_w, next_freq_run;

  // ==================================================
  // Channel qualifiers
  // Polarity applied per channel before the pair check
  for (genvar c = 0; c < NC; c++) begin : g_ch
    tdl_pulse_qual u_qual (
      .clock(clock),
      .sys_rst(sys_rst),
      .sample(samples[c]),
      .thresh(thr[c]),
      .invert(trig_inv[c]),
      .pulse(pulse_w[c])
    );
  end

  // ==================================================
  // Hold-time tick, pair diagnostic and error hold
  always_comb begin
    // Free-running divider makes the hold tick
    tick = (tick_cnt == TW'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
    // Each pair judged on its own
    for (int p = 0; p < NP; p++) begin
      // Both trains low at once, pair shares one enable
      dual_low[p] = dual_en[p] & ~pulse_w[2*p] & ~pulse_w[2*p+1];
      // Dual low reloads the hold, else tick counts down
      next_hold_cnt[p] = hold_cnt[p];
      if (dual_low[p]) begin
        next_hold_cnt[p] = hold_val;
      end else if (tick && hold_cnt[p] != '0) begin
        next_hold_cnt[p] = hold_cnt[p] - tdl_pkg::HOLD_W'(1);
      end
      // Fault shows while low or while the hold runs
      next_pair_fault[p] = dual_low[p] | (hold_cnt[p] != '0);
    end
  end

  // Diagnostic registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // Outputs and counters start clear
      tick_cnt <= '0;
      for (int p = 0; p < NP; p++) begin
        hold_cnt[p] <= '0;
      end
      pair_fault <= '0;
      pulse_state <= '0;
    end else begin
      // Register next values
      tick_cnt <= next_tick_cnt;
      for (int p = 0; p < NP; p++) begin
        hold_cnt[p] <= next_hold_cnt[p];
      end
      pair_fault <= next_pair_fault;
      pulse_state <= pulse_w;
    end
  end

  // ==================================================
  // Register writes, reads, sticky status and interrupt
  always_comb begin
    // Registers hold unless written or set by events; read data defaults to zero
    next_dual_en = dual_en;
    next_trig_inv = trig_inv;
    next_thr = thr;
    next_hold_val = hold_val;
    next_mask = mask;
    next_stat = stat;
    next_ovf_lat = ovf_lat;
    next_rdata = '0;
    // Write decode on exact byte addresses
    if (wr) begin
      if (addr == tdl_pkg::ADR_CTRL) begin
        next_dual_en = wdata[tdl_pkg::CTRL_DUAL_LSB +: NP];
        next_trig_inv = wdata[tdl_pkg::CTRL_TRIG_LSB +: NC];
      end else if (addr >= tdl_pkg::ADR_THR0 && addr <= tdl_pkg::ADR_THR3
                   && addr[1:0] == 2'h0) begin
        // Channel index from the word address
        next_thr[addr[4:2] - 3'h1].off_v =
          wdata[tdl_pkg::THR_OFF_LSB +: tdl_pkg::VOLT_W];
        next_thr[addr[4:2] - 3'h1].on_v =
          wdata[tdl_pkg::THR_ON_LSB +: tdl_pkg::VOLT_W];
      end else if (addr == tdl_pkg::ADR_HOLD) begin
        next_hold_val = wdata[tdl_pkg::HOLD_W-1:0];
      end else if (addr == tdl_pkg::ADR_STAT) begin
        // Write one to clear
        next_stat = stat & ~wdata[SW-1:0];
      end else if (addr == tdl_pkg::ADR_MASK) begin
        next_mask = wdata[SW-1:0];
      end else if (addr == tdl_pkg::ADR_TRST) begin
        // Tach reset per channel
        next_ovf_lat = ovf_lat & ~wdata[NC-1:0];
      end
    end

    // Events set after clears, so a set wins
    next_ovf_lat = next_ovf_lat | overfreq_evt;
    next_stat = next_stat | {overfreq_evt, dual_low};
    // Interrupt and run flags follow the new latches
    next_irq = |(next_stat & next_mask);
    next_freq_run = ~next_ovf_lat;

    // Read decode, unmapped addresses give zero
    if (rd) begin
      if (addr == tdl_pkg::ADR_CTRL) begin
        next_rdata[tdl_pkg::CTRL_DUAL_LSB +: NP] = dual_en;
        next_rdata[tdl_pkg::CTRL_TRIG_LSB +: NC] = trig_inv;
      end else if (addr >= tdl_pkg::ADR_THR0 && addr <= tdl_pkg::ADR_THR3
                   && addr[1:0] == 2'h0) begin
        // Same index as the write path
        next_rdata[tdl_pkg::THR_OFF_LSB +: tdl_pkg::VOLT_W] =
          thr[addr[4:2] - 3'h1].off_v;
        next_rdata[tdl_pkg::THR_ON_LSB +: tdl_pkg::VOLT_W] =
          thr[addr[4:2] - 3'h1].on_v;
      end else if (addr == tdl_pkg::ADR_HOLD) begin
        next_rdata[tdl_pkg::HOLD_W-1:0] = hold_val;
      end else if (addr == tdl_pkg::ADR_STAT) begin
        next_rdata[SW-1:0] = stat;
      end else if (addr == tdl_pkg::ADR_MASK) begin
        next_rdata[SW-1:0] = mask;
      end else if (addr == tdl_pkg::ADR_TRST) begin
        next_rdata[NC-1:0] = ovf_lat;
      end else if (addr == tdl_pkg::ADR_LIVE) begin
        // Live pulse and pair fault view
        next_rdata[NC-1:0] = pulse_state;
        next_rdata[NC +: NP] = pair_fault;
      end
    end
  end

  // Configuration, status and output registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // Defaults: diagnostic off, falling edge
      dual_en <= '0;
      trig_inv <= '0;
      for (int c = 0; c < NC; c++) begin
        // Per channel threshold defaults
        thr[c].off_v <= tdl_pkg::OFF_RST;
        thr[c].on_v <= tdl_pkg::ON_RST;
      end
      hold_val <= '0;
      stat <= '0;
      mask <= '0;
      ovf_lat <= '0;
      rdata <= '0;
      irq <= 1'b0;
      freq_run <= '1;
    end else begin
      // Take next values
      dual_en <= next_dual_en;
      trig_inv <= next_trig_inv;
      thr <= next_thr;
      hold_val <= next_hold_val;
      stat <= next_stat;
      mask <= next_mask;
      ovf_lat <= next_ovf_lat;
      rdata <= next_rdata;
      irq <= next_irq;
      freq_run <= next_freq_run;
    end
  end
endmodule : tdl_monitor

// ===== verif/tdl_monitor_properties.sv
// Checker: port-level properties of the tach monitor
`timescale 1ns/1ps
module tdl_monitor_chk #(
  parameter int TICK_CYCLES = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Sensor side and status
  input tdl_pkg::tdl_sample_t [3:0] samples,
  input wire logic [3:0] overfreq_evt,
  input wire logic [3:0] pulse_state,
  input wire logic [1:0] pair_fault,
  input wire logic [3:0] freq_run,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic ctl_seen;
  logic next_ctl_seen;
  logic trst2;
  // Remembers a control write since reset
  always_comb next_ctl_seen = ctl_seen | (wr && addr == tdl_pkg::ADR_CTRL);
  always_ff @(posedge clock) ctl_seen <= sys_rst ? 1'b0 : next_ctl_seen;
  // Tach reset of channel 2, the channel the scenarios exercise
  assign trst2 = wr && addr == tdl_pkg::ADR_TRST && wdata[2];
  // ==================================================
  // Properties
  property p_ovf_stop; overfreq_evt[2] |=> !freq_run[2]; endproperty
  a_ovf_stop: assert property (p_ovf_stop)
    else $error("freq_run did not stop");
  property p_ovf_hold;
    !freq_run[2] && !trst2 && !$past(trst2) |=> !freq_run[2];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("freq_run resumed without reset");
  property p_ovf_clr; trst2 && !overfreq_evt[2] |=> freq_run[2]; endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("freq_run not resumed");
  property p_pf_rise0; $rose(pair_fault[0]) |-> pulse_state[1:0] == 2'b00;
  endproperty
  a_pf_rise0: assert property (p_pf_rise0)
    else $error("pair 0 fault without dual low");
  property p_pf_rise1; $rose(pair_fault[1]) |-> pulse_state[3:2] == 2'b00;
  endproperty
  a_pf_rise1: assert property (p_pf_rise1)
    else $error("pair 1 fault without dual low");
  property p_pf_fall;
    $fell(pair_fault[0]) |-> pulse_state[1:0] != 2'b00 || $past(wr) ||
      $past(wr, 2);
  endproperty
  a_pf_fall: assert property (p_pf_fall)
    else $error("pair 0 fault dropped while low");
  property p_hyst;
    $changed(pulse_state[0]) |-> $past(samples[0].valid, 2) || $past(wr) ||
      $past(wr, 2) || $past(wr, 3);
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("pulse changed without sample");
  property p_dual_off; !ctl_seen |-> pair_fault == 2'b00; endproperty
  a_dual_off: assert property (p_dual_off)
    else $error("fault while diagnostic off");
  // Main scenarios reached
  c_pair0: cover property (pair_fault[0]);
  c_ovf: cover property (!freq_run[2]);
  c_irq: cover property ($rose(irq));
endmodule : tdl_monitor_chk

bind tdl_monitor tdl_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .samples,
  .overfreq_evt, .pulse_state, .pair_fault, .freq_run, .irq);

// ===== verif/tdl_sensor_model.sv
// Model of two pairs of tach sensors sending voltage samples
`timescale 1ns/1ps
module tdl_sensor_model (
  // Clock
  input wire logic clock,
  // Volts per channel, 5 bits each, and sample enable
  input wire logic [19:0] volts,
  input wire logic run,
  // Samples to the monitor
  output tdl_pkg::tdl_sample_t [3:0] samples
);
  // Fresh sample each cycle while running
  always_ff @(posedge clock) begin
    for (int c = 0; c < 4; c++) begin
      samples[c].valid <= run;
      samples[c].level <= {3'h0, volts[5*c +: 5], 8'h00};
    end
  end
endmodule : tdl_sensor_model

// ===== verif/tb.sv
// Testbench: tach monitor scenarios
`timescale 1ns/1ps
module tb;
  logic clock = 0;
  logic sys_rst = 1;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic run = 1;
  logic [19:0] volts = 0;
  logic [3:0] overfreq_evt = 0;
  logic [31:0] rdata;
  tdl_pkg::tdl_sample_t [3:0] samples;
  logic [3:0] pulse_state;
  logic [3:0] freq_run;
  logic [1:0] pair_fault;
  logic irq;
  int miscompares = 0;
  int tests_run = 0;
  // Clock and instances
  always #2.5 clock = ~clock;
  tdl_sensor_model model (.clock, .volts, .run, .samples);
  tdl_monitor #(.TICK_CYCLES(8)) uut (.clock, .sys_rst, .addr, .wdata,
    .wr, .rd, .rdata, .samples, .overfreq_evt, .pulse_state, .pair_fault,
    .freq_run, .irq);
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic wt(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clock);
    wr <= 0;
  endtask : wr_reg
  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1;
    @(posedge clock);
    rd <= 0;
    #1 check(n, e, rdata);
  endtask : rd_chk
  task automatic set_v(logic [19:0] v);
    @(posedge clock);
    volts <= v;
  endtask : set_v
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic t_reset;
    rd_chk("ctrl", 8'h00, 32'h0000_0000);
    rd_chk("thr0", 8'h04, 32'h0000_0B05);
    check("freq_run", 32'h0000_000F, 32'(freq_run));
    wr_reg(8'h30, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h30, 32'h0000_0000);
  endtask : t_reset
  task automatic t_hyst;
    logic [4:0] v[9] = '{12, 8, 5, 8, 11, 1, 0, 23, 24};
    logic e[9] = '{1, 1, 0, 0, 1, 1, 0, 0, 1};
    for (int i = 0; i < 9; i++) begin
      if (i == 5) wr_reg(8'h04, 32'h0000_1800);
      set_v({volts[19:5], v[i]});
      wt(4);
      check("pulse0", 32'(e[i]), 32'(pulse_state[0]));
    end
    // Samples without valid leave the state alone
    @(posedge clock);
    run <= 0;
    set_v({volts[19:5], 5'd0});
    wt(4);
    check("pulse0 idle", 32'h0000_0001, 32'(pulse_state[0]));
    @(posedge clock);
    run <= 1;
  endtask : t_hyst
  task automatic t_trig;
    set_v({volts[19:10], 5'd12, volts[4:0]});
    wt(4);
    check("pulse1", 32'h0000_0001, 32'(pulse_state[1]));
    wr_reg(8'h00, 32'h0000_0020);
    wt(3);
    check("pulse1 inv", 32'h0000_0000, 32'(pulse_state[1]));
    wr_reg(8'h00, 32'h0000_0000);
  endtask : t_trig
  task automatic t_dual;
    set_v({5'd12, 5'd12, 5'd0, 5'd0});
    wt(4);
    check("fault off", 32'h0000_0000, 32'(pair_fault));
    wr_reg(8'h00, 32'h0000_0001);
    wr_reg(8'h14, 32'h0000_0002);
    wr_reg(8'h1C, 32'h0000_0001);
    wt(3);
    check("fault on", 32'h0000_0001, 32'(pair_fault));
    check("irq on", 32'h0000_0001, 32'(irq));
    rd_chk("status", 8'h18, 32'h0000_0001);
    set_v({5'd12, 5'd12, 5'd0, 5'd24});
    wt(4);
    check("fault held", 32'h0000_0001, 32'(pair_fault));
    wt(30);
    check("fault gone", 32'h0000_0000, 32'(pair_fault));
    wr_reg(8'h18, 32'h0000_0001);
    wt(2);
    check("irq off", 32'h0000_0000, 32'(irq));
    wr_reg(8'h14, 32'h0000_0000);
    set_v({5'd0, 5'd0, 5'd0, 5'd24});
    wr_reg(8'h00, 32'h0000_0003);
    wt(4);
    check("fault pair1", 32'h0000_0002, 32'(pair_fault));
    rd_chk("live", 8'h24, 32'h0000_0021);
    wr_reg(8'h00, 32'h0000_0000);
    wt(3);
    check("fault cleared", 32'h0000_0000, 32'(pair_fault));
  endtask : t_dual
  task automatic t_ovf;
    @(posedge clock);
    overfreq_evt <= 4'h4;
    @(posedge clock);
    overfreq_evt <= 4'h0;
    wt(2);
    check("freq_run", 32'h0000_000B, 32'(freq_run));
    rd_chk("latch", 8'h20, 32'h0000_0004);
    wr_reg(8'h20, 32'h0000_0004);
    wt(2);
    check("freq_run", 32'h0000_000F, 32'(freq_run));
  endtask : t_ovf
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 0;
    t_reset();
    t_hyst();
    t_trig();
    t_dual();
    t_ovf();
    complete_run();
  end
  // Watchdog
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule : tb
